/* design/dmcp_pkg.sv */
// Purpose: shared constants and types of the dual mode control port
// Assumes: 8-bit register addresses and data, one system clock
// Notes:   two-wire slave addresses are 7-bit values
package dmcp_pkg;

  // register space
  localparam int unsigned REG_COUNT        = 256;
  localparam logic [7:0]  REG_RESET_VALUE  = 8'h00;

  // two-wire slave address: fixed base plus two select pins
  localparam logic [6:0]  I2C_BASE_ADDR    = 7'h04;
  localparam int unsigned I2C_SEL_HI_POS   = 6;
  localparam int unsigned I2C_SEL_LO_POS   = 5;
  localparam logic [3:0]  I2C_BYTE_DONE    = 4'h8;

  // four-wire chip address and frame layout
  localparam logic [6:0]  SPI_CHIP_ADDR    = 7'h06;
  localparam logic [2:0]  SPI_LAST_BIT     = 3'h7;
  localparam logic [1:0]  SPI_DUMMY_LAST   = 2'h2;
  localparam logic [1:0]  SPI_IDX_CHIP     = 2'h0;
  localparam logic [1:0]  SPI_IDX_REG      = 2'h1;
  localparam logic [1:0]  SPI_IDX_DATA     = 2'h2;

  // strap capture waits out the pin synchroniser
  localparam logic [1:0]  STRAP_WAIT       = 2'h3;

  // synchronised pin vector positions
  localparam int unsigned PIN_SCL          = 0;
  localparam int unsigned PIN_SDA          = 1;
  localparam int unsigned PIN_SS_N         = 2;
  localparam int unsigned PIN_MOSI         = 3;
  localparam int unsigned PIN_PU_N         = 4;
  localparam int unsigned PIN_SA           = 5;
  localparam int unsigned PIN_SEL_HI       = 6;
  localparam int unsigned PIN_SEL_LO       = 7;
  localparam int unsigned PIN_COUNT        = 8;

  // two-wire transaction states
  typedef enum logic [2:0] {
    DMCP_I2C_IDLE   = 3'b000,
    DMCP_I2C_ADDR   = 3'b001,
    DMCP_I2C_REG    = 3'b010,
    DMCP_I2C_DATA   = 3'b011,
    DMCP_I2C_ACK    = 3'b100,
    DMCP_I2C_RD     = 3'b101,
    DMCP_I2C_IGNORE = 3'b110
  } dmcp_i2c_state_e;

endpackage

/* design/dmcp_pin_sync.sv */
// Purpose: two-flop synchroniser with edge detection for a group of pins
// Assumes: pins are asynchronous to clk_sys_in
// Notes:   edges compare the second stage with a third, never the first
module dmcp_pin_sync #(
  parameter int unsigned WIDTH = 8
) (
  // clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             rst_n_in,
  // raw pins
  input  wire logic [WIDTH-1:0] pin_in,
  // synchronised level and edges
  output logic      [WIDTH-1:0] level_out,
  output logic      [WIDTH-1:0] rise_out,
  output logic      [WIDTH-1:0] fall_out
);

  genvar g;

  // one synchroniser chain per pin
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : gen_sync
      logic stage1;
      logic stage2;
      logic stage3;

      // first stage feeds only the second
      always_ff @(posedge clk_sys_in or negedge rst_n_in)
      begin
        if (!rst_n_in)
        begin
          stage1 <= 1'b0;
          stage2 <= 1'b0;
          stage3 <= 1'b0;
        end
        else
        begin
          stage1 <= pin_in[g];
          stage2 <= stage1;
          stage3 <= stage2;
        end
      end

      // level and edges from the settled stages
      assign level_out[g] = stage2;
      assign rise_out[g]  = stage2 & ~stage3;
      assign fall_out[g]  = ~stage2 & stage3;
    end
  endgenerate

endmodule

/* design/dmcp_control_port.sv */
// Purpose: register control port reached over a two-wire or a four-wire serial link
// Assumes: link pins are slow against clk_sys_in (10 MHz) and are sampled by it
// Notes:   rst_n_in stands for a full power cycle; four-wire mode is left only by it
module dmcp_control_port (
  // clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_n_in,
  // shared serial clock and two-wire data
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  // four-wire link
  input  wire logic       ss_n_in,
  input  wire logic       mosi_in,
  output logic            miso_out,
  output logic            miso_oe_out,
  // straps and power pins
  input  wire logic       bus_addr_select_hi_in,
  input  wire logic       bus_addr_select_lo_in,
  input  wire logic       standalone_select_in,
  input  wire logic       powerup_reset_n_in,
  // master clock path
  input  wire logic       master_clock_in,
  output logic            master_clock_out,
  // register write notification and status
  output logic            reg_wr_pulse_out,
  output logic [7:0]      reg_wr_addr_out,
  output logic [7:0]      reg_wr_data_out,
  output logic            spi_mode_out,
  output logic            standalone_out
);

  // synchronised pins
  logic [dmcp_pkg::PIN_COUNT-1:0] pin_raw;
  logic [dmcp_pkg::PIN_COUNT-1:0] pin_lvl;
  logic [dmcp_pkg::PIN_COUNT-1:0] pin_rise;
  logic [dmcp_pkg::PIN_COUNT-1:0] pin_fall;

  // mode control
  logic [1:0] strap_cnt;
  logic       strap_done;
  logic       standalone;
  logic       spi_mode;
  logic [1:0] dummy_cnt;
  logic       active;
  logic       i2c_en;
  logic       spi_en;

  // register storage
  logic [7:0] reg_file [0:dmcp_pkg::REG_COUNT-1];

  // two-wire engine
  dmcp_pkg::dmcp_i2c_state_e i2c_state;
  dmcp_pkg::dmcp_i2c_state_e i2c_ack_next;
  logic [3:0] i2c_cnt;
  logic [7:0] i2c_shift;
  logic [7:0] i2c_tx;
  logic [7:0] i2c_ptr;
  logic [7:0] i2c_rd_data;
  logic       i2c_start;
  logic       i2c_stop;
  logic       i2c_wr;
  logic [7:0] i2c_wdata;
  logic       sda_drive;

  // four-wire engine
  logic [2:0] spi_cnt;
  logic [1:0] spi_idx;
  logic [7:0] spi_shift;
  logic [7:0] spi_byte;
  logic [7:0] spi_tx;
  logic [7:0] spi_ptr;
  logic [7:0] spi_ptr_inc;
  logic       spi_rw;
  logic       spi_chip_ok;
  logic       spi_wr;
  logic [7:0] spi_waddr;
  logic [7:0] spi_wdata;

  // address match against seven upper bits of a received byte
  function automatic logic addr_match(input logic [7:0] rx, input logic [6:0] addr);
    addr_match = (rx[7:1] == addr);
  endfunction

  // pin synchronisers for every asynchronous link, strap and power pin; master_clock_in passes unsynchronised
  assign pin_raw[dmcp_pkg::PIN_SCL]    = scl_in;
  assign pin_raw[dmcp_pkg::PIN_SDA]    = sda_in;
  assign pin_raw[dmcp_pkg::PIN_SS_N]   = ss_n_in;
  assign pin_raw[dmcp_pkg::PIN_MOSI]   = mosi_in;
  assign pin_raw[dmcp_pkg::PIN_PU_N]   = powerup_reset_n_in;
  assign pin_raw[dmcp_pkg::PIN_SA]     = standalone_select_in;
  assign pin_raw[dmcp_pkg::PIN_SEL_HI] = bus_addr_select_hi_in;
  assign pin_raw[dmcp_pkg::PIN_SEL_LO] = bus_addr_select_lo_in;

  dmcp_pin_sync #(
    .WIDTH (dmcp_pkg::PIN_COUNT)
  ) u_pin_sync (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .pin_in     (pin_raw),
    .level_out  (pin_lvl),
    .rise_out   (pin_rise),
    .fall_out   (pin_fall)
  );

  // standalone strap caught once the synchroniser has settled
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      strap_cnt  <= 2'h0;
      strap_done <= 1'b0;
      standalone <= 1'b0;
    end
    else if (!strap_done)
    begin
      if (strap_cnt == dmcp_pkg::STRAP_WAIT)
      begin
        strap_done <= 1'b1;
        standalone <= pin_lvl[dmcp_pkg::PIN_SA];
      end
      else
      begin
        strap_cnt <= strap_cnt + 2'h1;
      end
    end
  end

  // serial control only when not standalone and powered up
  assign active = strap_done & ~standalone & pin_lvl[dmcp_pkg::PIN_PU_N];
  assign i2c_en = active & ~spi_mode;
  assign spi_en = active & spi_mode;

  // buffered master clock in standalone mode while powered up
  assign master_clock_out = master_clock_in & standalone & pin_lvl[dmcp_pkg::PIN_PU_N];

  // interface selection: three dummy select pulses, then sticky
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      spi_mode  <= 1'b0;
      dummy_cnt <= 2'h0;
    end
    else if (active && !spi_mode && pin_rise[dmcp_pkg::PIN_SS_N])
    begin
      if (dummy_cnt == dmcp_pkg::SPI_DUMMY_LAST)
      begin
        spi_mode <= 1'b1;
      end
      else
      begin
        dummy_cnt <= dummy_cnt + 2'h1;
      end
    end
  end

  // two-wire bus conditions
  assign i2c_start   = pin_fall[dmcp_pkg::PIN_SDA] & pin_lvl[dmcp_pkg::PIN_SCL];
  assign i2c_stop    = pin_rise[dmcp_pkg::PIN_SDA] & pin_lvl[dmcp_pkg::PIN_SCL];
  assign i2c_rd_data = reg_file[i2c_ptr];

  // two-wire transaction engine
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      i2c_state    <= dmcp_pkg::DMCP_I2C_IDLE;
      i2c_ack_next <= dmcp_pkg::DMCP_I2C_IDLE;
      i2c_cnt      <= 4'h0;
      i2c_shift    <= 8'h00;
      i2c_tx       <= 8'h00;
      i2c_ptr      <= 8'h00;
      i2c_wr       <= 1'b0;
      i2c_wdata    <= 8'h00;
      sda_drive    <= 1'b0;
    end
    else
    begin
      i2c_wr <= 1'b0;
      if (!i2c_en)
      begin
        i2c_state <= dmcp_pkg::DMCP_I2C_IDLE;
        sda_drive <= 1'b0;
      end
      else if (i2c_start)
      begin
        i2c_state <= dmcp_pkg::DMCP_I2C_ADDR;
        i2c_cnt   <= 4'h0;
        sda_drive <= 1'b0;
      end
      else if (i2c_stop)
      begin
        i2c_state <= dmcp_pkg::DMCP_I2C_IDLE;
        sda_drive <= 1'b0;
      end
      else if (pin_rise[dmcp_pkg::PIN_SCL])
      begin
        // sample data while the clock is high
        if (i2c_state == dmcp_pkg::DMCP_I2C_ADDR || i2c_state == dmcp_pkg::DMCP_I2C_REG ||
            i2c_state == dmcp_pkg::DMCP_I2C_DATA)
        begin
          i2c_shift <= {i2c_shift[6:0], pin_lvl[dmcp_pkg::PIN_SDA]};
          i2c_cnt   <= i2c_cnt + 4'h1;
        end
      end
      else if (pin_fall[dmcp_pkg::PIN_SCL])
      begin
        // drive changes only while the clock is low
        case (i2c_state)
          dmcp_pkg::DMCP_I2C_ADDR:
          begin
            if (i2c_cnt == dmcp_pkg::I2C_BYTE_DONE)
            begin
              if (addr_match(i2c_shift, dmcp_pkg::I2C_BASE_ADDR |
                  {pin_lvl[dmcp_pkg::PIN_SEL_HI], pin_lvl[dmcp_pkg::PIN_SEL_LO], 5'h00}))
              begin
                i2c_state    <= dmcp_pkg::DMCP_I2C_ACK;
                sda_drive    <= 1'b1;
                i2c_ack_next <= i2c_shift[0] ? dmcp_pkg::DMCP_I2C_RD : dmcp_pkg::DMCP_I2C_REG;
              end
              else
              begin
                i2c_state <= dmcp_pkg::DMCP_I2C_IGNORE;
              end
            end
          end
          dmcp_pkg::DMCP_I2C_REG:
          begin
            if (i2c_cnt == dmcp_pkg::I2C_BYTE_DONE)
            begin
              i2c_ptr      <= i2c_shift;
              i2c_state    <= dmcp_pkg::DMCP_I2C_ACK;
              sda_drive    <= 1'b1;
              i2c_ack_next <= dmcp_pkg::DMCP_I2C_DATA;
            end
          end
          dmcp_pkg::DMCP_I2C_DATA:
          begin
            if (i2c_cnt == dmcp_pkg::I2C_BYTE_DONE)
            begin
              i2c_wr       <= 1'b1;
              i2c_wdata    <= i2c_shift;
              i2c_state    <= dmcp_pkg::DMCP_I2C_ACK;
              sda_drive    <= 1'b1;
              i2c_ack_next <= dmcp_pkg::DMCP_I2C_IGNORE;
            end
          end
          dmcp_pkg::DMCP_I2C_ACK:
          begin
            i2c_state <= i2c_ack_next;
            i2c_cnt   <= 4'h0;
            if (i2c_ack_next == dmcp_pkg::DMCP_I2C_RD)
            begin
              sda_drive <= ~i2c_rd_data[7];
              i2c_tx    <= {i2c_rd_data[6:0], 1'b0};
              i2c_cnt   <= 4'h1;
            end
            else
            begin
              sda_drive <= 1'b0;
            end
          end
          dmcp_pkg::DMCP_I2C_RD:
          begin
            if (i2c_cnt == dmcp_pkg::I2C_BYTE_DONE)
            begin
              sda_drive <= 1'b0;
              i2c_state <= dmcp_pkg::DMCP_I2C_IGNORE;
            end
            else
            begin
              sda_drive <= ~i2c_tx[7];
              i2c_tx    <= {i2c_tx[6:0], 1'b0};
              i2c_cnt   <= i2c_cnt + 4'h1;
            end
          end
          default:
          begin
            sda_drive <= 1'b0;
          end
        endcase
      end
    end
  end

  // open-drain data pin only ever pulls low
  assign sda_out    = 1'b0;
  assign sda_oe_out = sda_drive;

  // four-wire frame engine
  assign spi_byte    = {spi_shift[6:0], pin_lvl[dmcp_pkg::PIN_MOSI]};
  assign spi_ptr_inc = spi_ptr + 8'h01;

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      spi_cnt     <= 3'h0;
      spi_idx     <= dmcp_pkg::SPI_IDX_CHIP;
      spi_shift   <= 8'h00;
      spi_tx      <= 8'h00;
      spi_ptr     <= 8'h00;
      spi_rw      <= 1'b0;
      spi_chip_ok <= 1'b0;
      spi_wr      <= 1'b0;
      spi_waddr   <= 8'h00;
      spi_wdata   <= 8'h00;
    end
    else
    begin
      spi_wr <= 1'b0;
      if (!spi_en || pin_lvl[dmcp_pkg::PIN_SS_N])
      begin
        // select high ends the frame; partial bytes are dropped
        spi_cnt     <= 3'h0;
        spi_idx     <= dmcp_pkg::SPI_IDX_CHIP;
        spi_chip_ok <= 1'b0;
      end
      else if (pin_rise[dmcp_pkg::PIN_SCL])
      begin
        spi_shift <= spi_byte;
        spi_cnt   <= spi_cnt + 3'h1;
        if (spi_cnt == dmcp_pkg::SPI_LAST_BIT)
        begin
          case (spi_idx)
            dmcp_pkg::SPI_IDX_CHIP:
            begin
              spi_chip_ok <= addr_match(spi_byte, dmcp_pkg::SPI_CHIP_ADDR);
              spi_rw      <= spi_byte[0];
              spi_idx     <= dmcp_pkg::SPI_IDX_REG;
            end
            dmcp_pkg::SPI_IDX_REG:
            begin
              spi_ptr <= spi_byte;
              spi_tx  <= reg_file[spi_byte];
              spi_idx <= dmcp_pkg::SPI_IDX_DATA;
            end
            default:
            begin
              if (spi_chip_ok && !spi_rw)
              begin
                spi_wr    <= 1'b1;
                spi_waddr <= spi_ptr;
                spi_wdata <= spi_byte;
              end
              spi_ptr <= spi_ptr_inc;
              spi_tx  <= reg_file[spi_ptr_inc];
            end
          endcase
        end
      end
      else if (pin_fall[dmcp_pkg::PIN_SCL] && spi_cnt != 3'h0)
      begin
        // first bit of a byte is presented by the load itself
        spi_tx <= {spi_tx[6:0], 1'b0};
      end
    end
  end

  // serial output driven only in the data bytes of a read
  assign miso_out    = spi_tx[7];
  assign miso_oe_out = spi_en & ~pin_lvl[dmcp_pkg::PIN_SS_N] & spi_chip_ok & spi_rw &
                       (spi_idx == dmcp_pkg::SPI_IDX_DATA);

  // register storage and write notification
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      for (int i = 0; i < dmcp_pkg::REG_COUNT; i++)
      begin
        reg_file[i] <= dmcp_pkg::REG_RESET_VALUE;
      end
      reg_wr_pulse_out <= 1'b0;
      reg_wr_addr_out  <= 8'h00;
      reg_wr_data_out  <= 8'h00;
    end
    else
    begin
      reg_wr_pulse_out <= i2c_wr | spi_wr;
      if (i2c_wr)
      begin
        reg_file[i2c_ptr] <= i2c_wdata;
        reg_wr_addr_out   <= i2c_ptr;
        reg_wr_data_out   <= i2c_wdata;
      end
      else if (spi_wr)
      begin
        reg_file[spi_waddr] <= spi_wdata;
        reg_wr_addr_out     <= spi_waddr;
        reg_wr_data_out     <= spi_wdata;
      end
    end
  end

  // status outputs
  assign spi_mode_out   = spi_mode;
  assign standalone_out = standalone;

endmodule

/* dv/dmcp_control_port_properties.sv */
// Purpose: port-level checks of the dual mode control port
// Assumes: link pins run slow against clk_sys_in
// Notes:   bound to the design top from the bench top file
module dmcp_control_port_properties (
  // clock and reset
  input  wire logic clk_sys_in,
  input  wire logic rst_n_in,
  // link pins
  input  wire logic scl_in,
  input  wire logic ss_n_in,
  input  wire logic sda_out,
  input  wire logic sda_oe_out,
  input  wire logic miso_oe_out,
  // clock path and status
  input  wire logic powerup_reset_n_in,
  input  wire logic master_clock_in,
  input  wire logic master_clock_out,
  input  wire logic reg_wr_pulse_out,
  input  wire logic spi_mode_out,
  input  wire logic standalone_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // one clock domain for every check
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);

  // open drain only ever pulls low
  a_sda_pull_low: assert property (sda_oe_out |-> !sda_out)
    else $error("data pin driven high");
  // data pin moves only while the serial clock is low
  a_sda_move_low: assert property ($changed(sda_oe_out) |-> !scl_in)
    else $error("data pin moved while clock high");
  // serial output driven only in four-wire mode
  a_miso_in_mode: assert property (miso_oe_out |-> spi_mode_out && !standalone_out)
    else $error("serial output driven outside four-wire mode");
  // serial output released while deselected
  a_miso_off_idle: assert property (ss_n_in && $past(ss_n_in, 5) |-> !miso_oe_out)
    else $error("serial output driven while deselected");
  // four-wire mode never leaves without reset
  a_spi_mode_kept: assert property (spi_mode_out |=> spi_mode_out)
    else $error("four-wire mode dropped");
  // two-wire engine silent in four-wire mode
  a_spi_mutes_i2c: assert property (spi_mode_out |-> !sda_oe_out)
    else $error("two-wire answer in four-wire mode");
  // clock output dark without standalone
  a_mclk_dark: assert property (!standalone_out |-> !master_clock_out)
    else $error("clock output active without standalone");
  // clock output copies the input once powered
  a_mclk_copy: assert property (standalone_out && powerup_reset_n_in && $past(powerup_reset_n_in, 3)
                                |-> master_clock_out == master_clock_in)
    else $error("clock output differs from input");
  // strap result holds until reset
  a_strap_kept: assert property (standalone_out |=> standalone_out)
    else $error("standalone flag dropped");
  // four-wire writes land only inside a frame
  a_wr_in_frame: assert property (reg_wr_pulse_out && spi_mode_out |-> !$past(ss_n_in, 2))
    else $error("four-wire write outside a frame");
endmodule

/* dv/dmcp_host_model.sv */
// Purpose: host master driving the two-wire and four-wire links
// Assumes: link clock period 800 ns, free of the system clock
// Notes:   data wire has a pull-up; an undriven serial output reads as noise
module dmcp_host_model (
  // system clock for the noise source
  input  wire logic clk_sys_in,
  // device side
  input  wire logic sda_out_in,
  input  wire logic sda_oe_in,
  input  wire logic miso_in,
  input  wire logic miso_oe_in,
  // host driven pins
  output logic      scl_out,
  output logic      sda_wire_out,
  output logic      ss_n_out,
  output logic      mosi_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sda_host = 1'b1;
  logic noise    = 1'b0;
  logic miso_w;

  // wired pins: pull-up on data, toggling noise on a floating output
  assign sda_wire_out = sda_host & ~(sda_oe_in & ~sda_out_in);
  assign miso_w = miso_oe_in ? miso_in : noise;
  always @(posedge clk_sys_in) noise <= ~noise;
  initial
  begin
    scl_out = 1'b1;
    ss_n_out = 1'b1;
    mosi_out = 1'b0;
  end

  // one bit: data set while clock low, sampled mid high phase
  task automatic i2c_bit(input logic b, output logic r);
    sda_host = b;
    #200 scl_out = 1'b1;
    #200 r = sda_wire_out;
    #200 scl_out = 1'b0;
    #200;
  endtask
  // start or repeated start: data falls while clock high
  task automatic i2c_start();
    sda_host = 1'b1;
    #200 scl_out = 1'b1;
    #400 sda_host = 1'b0;
    #400 scl_out = 1'b0;
    #200;
  endtask
  task automatic i2c_stop();
    sda_host = 1'b0;
    #200 scl_out = 1'b1;
    #400 sda_host = 1'b1;
    #400;
  endtask
  // byte msb first, ninth bit released
  task automatic i2c_byte(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--)
      i2c_bit(tx[i], rx[i]);
    i2c_bit(1'b1, b);
    ack = ~b;
  endtask
  // write, or pointer only when full is low
  task automatic i2c_write(input logic [6:0] a, input logic [7:0] r, d, input logic full, output logic [2:0] ack);
    logic [7:0] x;
    ack = 3'h0;
    i2c_start();
    i2c_byte({a, 1'b0}, x, ack[2]);
    i2c_byte(r, x, ack[1]);
    if (full) i2c_byte(d, x, ack[0]);
    i2c_stop();
  endtask
  // pointer write, repeated start, one byte, master nack
  task automatic i2c_read(input logic [6:0] a, input logic [7:0] r, output logic [7:0] d, output logic [2:0] ack);
    logic [7:0] x;
    logic       nack;
    i2c_start();
    i2c_byte({a, 1'b0}, x, ack[2]);
    i2c_byte(r, x, ack[1]);
    i2c_start();
    i2c_byte({a, 1'b1}, x, ack[0]);
    i2c_byte(8'hFF, d, nack);
    i2c_stop();
  endtask
  // select pulse with no clocking
  task automatic dummy_select();
    ss_n_out = 1'b0;
    #800 ss_n_out = 1'b1;
    #800;
  endtask
  // mode 0 frame of n bits, msb of tx first; read data and enable sampled at each rise
  task automatic spi_frame(input logic [31:0] tx, input int n, output logic [31:0] rx, oe);
    rx = 32'h0000_0000;
    oe = 32'h0000_0000;
    scl_out = 1'b0;
    #400 ss_n_out = 1'b0;
    for (int i = 31; i > 31 - n; i--)
    begin
      mosi_out = tx[i];
      #400 scl_out = 1'b1;
      rx[i] = miso_w;
      oe[i] = miso_oe_in;
      #400 scl_out = 1'b0;
    end
    #400 ss_n_out = 1'b1;
    mosi_out = ~mosi_out;
    #800;
  endtask
endmodule

/* dv/tb_dmcp_control_port.sv */
// Purpose: self-checking bench of the dual mode control port
// Assumes: host model drives both links at 800 ns per bit
// Notes:   second reset stands for a power cycle into standalone
module tb_dmcp_control_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic            clk_sys_in = 1'b0;
  logic            rst_n_in   = 1'b0;
  logic            sel_hi     = 1'b0;
  logic            sel_lo     = 1'b0;
  logic            sa_sel     = 1'b0;
  logic            pu_n       = 1'b1;
  logic            mclk       = 1'b0;
  wire logic       scl, sda, ss_n, mosi, sda_o, sda_oe, miso, miso_oe;
  wire logic       mclk_out, wr_pulse, spi_mode, sa_out;
  wire logic [7:0] wr_addr, wr_data;
  int              num_errors = 0;
  int              compares   = 0;
  int              cycles     = 0;
  int              wr_count   = 0;

  // clocks
  always #50 clk_sys_in = ~clk_sys_in;
  always #37 mclk = ~mclk;
  // write tally and run ceiling
  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (wr_pulse) wr_count++;
    if (cycles == 20000)
    begin
      num_errors++;
      final_report();
    end
  end

  dmcp_control_port u_dmcp_control_port (
    .clk_sys_in, .rst_n_in, .scl_in(scl), .sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe),
    .ss_n_in(ss_n), .mosi_in(mosi), .miso_out(miso), .miso_oe_out(miso_oe),
    .bus_addr_select_hi_in(sel_hi), .bus_addr_select_lo_in(sel_lo), .standalone_select_in(sa_sel),
    .powerup_reset_n_in(pu_n), .master_clock_in(mclk), .master_clock_out(mclk_out),
    .reg_wr_pulse_out(wr_pulse), .reg_wr_addr_out(wr_addr), .reg_wr_data_out(wr_data),
    .spi_mode_out(spi_mode), .standalone_out(sa_out));
  dmcp_host_model u_dmcp_host_model (
    .clk_sys_in, .sda_out_in(sda_o), .sda_oe_in(sda_oe), .miso_in(miso), .miso_oe_in(miso_oe),
    .scl_out(scl), .sda_wire_out(sda), .ss_n_out(ss_n), .mosi_out(mosi));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // two-wire address: base 0x04 with the select pins in bits 6 and 5
  function automatic logic [6:0] addr_of(input logic [1:0] s);
    return {s, 5'h04};
  endfunction
  task automatic reset_dut(input logic sa);
    @(posedge clk_sys_in);
    #10 rst_n_in = 1'b0;
    sa_sel = sa;
    repeat (12) @(posedge clk_sys_in);
    #10 rst_n_in = 1'b1;
    repeat (20) @(posedge clk_sys_in);
    #10;
  endtask

  // every select setting: foreign address, cut write, full write
  task automatic t_i2c_write();
    logic [2:0] ack;
    int         w0;
    for (int s = 0; s < 4; s++)
    begin
      {sel_hi, sel_lo} = 2'(s);
      w0 = wr_count;
      u_dmcp_host_model.i2c_write(addr_of(2'(s + 1)), 8'h10, 8'hFF, 1'b1, ack);
      check("foreign ack", {5'h00, ack}, 8'h00);
      u_dmcp_host_model.i2c_write(addr_of(2'(s)), 8'h10, 8'hEE, 1'b0, ack);
      check("cut ack", {5'h00, ack}, 8'h06);
      u_dmcp_host_model.i2c_write(addr_of(2'(s)), 8'(8'h10 + s), 8'(8'hA0 + s), 1'b1, ack);
      check("write ack", {5'h00, ack}, 8'h07);
      check("write count", 8'(wr_count - w0), 8'h01);
      check("write addr", wr_addr, 8'(8'h10 + s));
      check("write data", wr_data, 8'(8'hA0 + s));
    end
    check("clock out dark", {7'h00, mclk_out}, 8'h00);
    $display("test i2c_write done");
  endtask
  // read back a written and an untouched register
  task automatic t_i2c_read();
    logic [2:0] ack;
    logic [7:0] d;
    u_dmcp_host_model.i2c_read(addr_of(2'h3), 8'h12, d, ack);
    check("read ack", {5'h00, ack}, 8'h07);
    check("read data", d, 8'hA2);
    u_dmcp_host_model.i2c_read(addr_of(2'h3), 8'h33, d, ack);
    check("read reset value", d, 8'h00);
    $display("test i2c_read done");
  endtask
  // three dummy selects switch mode; two-wire then ignored
  task automatic t_spi_enter();
    logic [2:0] ack;
    for (int i = 1; i <= 3; i++)
    begin
      u_dmcp_host_model.dummy_select();
      check("mode after dummy", {7'h00, spi_mode}, 8'(i == 3));
    end
    u_dmcp_host_model.i2c_write(addr_of(2'h3), 8'h11, 8'h55, 1'b1, ack);
    check("two-wire after switch", {5'h00, ack}, 8'h00);
    check("mode kept", {7'h00, spi_mode}, 8'h01);
    $display("test spi_enter done");
  endtask
  // burst write, burst read, foreign chip, cut frame
  task automatic t_spi_burst();
    logic [31:0] rx;
    logic [31:0] oe;
    int          w0;
    w0 = wr_count;
    u_dmcp_host_model.spi_frame({7'h06, 1'b0, 8'h20, 16'h5AC3}, 32, rx, oe);
    check("burst count", 8'(wr_count - w0), 8'h02);
    check("burst addr", wr_addr, 8'h21);
    check("burst data", wr_data, 8'hC3);
    check("write keeps output off", oe[7:0], 8'h00);
    u_dmcp_host_model.spi_frame({7'h06, 1'b1, 8'h20, 16'h0000}, 32, rx, oe);
    check("read first", rx[15:8], 8'h5A);
    check("read second", rx[7:0], 8'hC3);
    check("enable byte one", oe[31:24], 8'h00);
    check("enable byte two", oe[23:16], 8'h00);
    check("enable byte three", oe[15:8], 8'hFF);
    u_dmcp_host_model.spi_frame({7'h07, 1'b0, 8'h20, 16'h7700}, 24, rx, oe);
    u_dmcp_host_model.spi_frame({7'h07, 1'b1, 8'h20, 16'h0000}, 24, rx, oe);
    check("foreign chip output", oe[15:8], 8'h00);
    u_dmcp_host_model.spi_frame({7'h06, 1'b0, 8'h30, 16'hA500}, 20, rx, oe);
    check("total writes", 8'(wr_count - w0), 8'h02);
    $display("test spi_burst done");
  endtask
  // power cycle into standalone: clock copy, then power pin low
  task automatic t_standalone();
    reset_dut(1'b1);
    check("strap", {7'h00, sa_out}, 8'h01);
    check("mode after power cycle", {7'h00, spi_mode}, 8'h00);
    repeat (4)
    begin
      @(mclk);
      #1;
      check("clock copy", {7'h00, mclk_out}, {7'h00, mclk});
    end
    @(posedge clk_sys_in);
    #10 pu_n = 1'b0;
    repeat (6) @(negedge clk_sys_in);
    check("clock gated", {7'h00, mclk_out}, 8'h00);
    $display("test standalone done");
  endtask

  initial
  begin
    reset_dut(1'b0);
    t_i2c_write();
    t_i2c_read();
    t_spi_enter();
    t_spi_burst();
    t_standalone();
    final_report();
  end
endmodule

bind dmcp_control_port dmcp_control_port_properties u_dmcp_control_port_properties (
  .clk_sys_in, .rst_n_in, .scl_in, .ss_n_in, .sda_out, .sda_oe_out, .miso_oe_out, .powerup_reset_n_in,
  .master_clock_in, .master_clock_out, .reg_wr_pulse_out, .spi_mode_out, .standalone_out);
